// ===== hw/serial_offset_pkg.sv
// Purpose: Shared constants for the serial offset frequency loader
// Assumes: Single 250 MHz clock, word lengths of 8/16/24/32 bits
// Notes:   Word length select codes map 0..3 to 8..32 bits
package serial_offset_pkg;
  // Holding register width
  localparam int unsigned HOLD_W = 32;
  // Word length select field width and codes
  localparam int unsigned LEN_SEL_W = 2;
  localparam logic [1:0] LEN_SEL_8  = 2'h0;
  localparam logic [1:0] LEN_SEL_16 = 2'h1;
  localparam logic [1:0] LEN_SEL_24 = 2'h2;
  localparam logic [1:0] LEN_SEL_32 = 2'h3;
  // Bit counter width, enough to hold 32
  localparam int unsigned CNT_W = 6;
  // Reset values
  localparam logic [31:0] HOLD_RST = 32'h0000_0000;
  localparam logic [5:0]  CNT_RST  = 6'h00;
  // Buffer depth of the output staging buffer
  localparam int unsigned BUF_DEPTH = 2;

  // Port receiver state
  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } rx_state_t;

  // Number of bits per word for a length select code
  function automatic logic [5:0] word_bits(input logic [1:0] sel);
    case (sel)
      LEN_SEL_8:  word_bits = 6'h08;
      LEN_SEL_16: word_bits = 6'h10;
      LEN_SEL_24: word_bits = 6'h18;
      default:    word_bits = 6'h20;
    endcase
  endfunction

  // Left-justify a received word, clearing unused low bits
  function automatic logic [31:0] left_justify(input logic [31:0] sh, input logic [1:0] sel);
    case (sel)
      LEN_SEL_8:  left_justify = {sh[7:0], 24'h000000};
      LEN_SEL_16: left_justify = {sh[15:0], 16'h0000};
      LEN_SEL_24: left_justify = {sh[23:0], 8'h00};
      default:    left_justify = sh;
    endcase
  endfunction
endpackage

// ===== hw/serial_offset_frequency_loader.sv
// Purpose: Two serial ports loading carrier and resampler offset words
// Assumes: Inputs synchronous to clk_sys_i; one clock domain
// Notes:   Each port feeds a two-entry buffer toward the holding register
`timescale 1ns/1ps

// Notes on behaviour
// - two independent ports, carrier and resampler
// - word length selectable 8, 16, 24, 32
// - data sampled on rising clock edge
// - start loads down-counter; shift bit per clock
// - after last bit, push into buffer; head entry is the holding register
// - shift register ready again next cycle
// - short words left-justified, low bits zeroed
// - back-to-back words allowed, no idle gap
module serial_offset_frequency_loader (
  // Clock and reset
  input  wire logic                              clk_sys_i,
  input  wire logic                              arst_n_i,
  // Word length selects
  input  wire logic [serial_offset_pkg::LEN_SEL_W-1:0] carrier_len_sel_i,
  input  wire logic [serial_offset_pkg::LEN_SEL_W-1:0] resampler_len_sel_i,
  // Carrier offset serial port
  input  wire logic                              carrier_offset_serial_data_i,
  input  wire logic                              carrier_word_start_i,
  // Resampler offset serial port
  input  wire logic                              resampler_offset_serial_data_i,
  input  wire logic                              resampler_word_start_i,
  // Holding register drain handshakes
  input  wire logic                              carrier_hold_ready_i,
  input  wire logic                              resampler_hold_ready_i,
  // Holding registers
  output logic [serial_offset_pkg::HOLD_W-1:0]   carrier_offset_hold_o,
  output logic                                   carrier_hold_valid_o,
  output logic [serial_offset_pkg::HOLD_W-1:0]   resampler_offset_hold_o,
  output logic                                   resampler_hold_valid_o,
  // Sticky overflow flags, set when a word completes while the buffer is full and not popping
  output logic                                   carrier_overflow_o,
  output logic                                   resampler_overflow_o
);
  import serial_offset_pkg::*;

  // Timing of one word on one port, start seen at edge E, N bits long:
  //   edge E          start sampled while idle; length latched, counter loaded
  //   edges E+1..E+N  one data bit shifted in per edge, first bit is the MSB
  //   edge E+N        last bit lands, receiver back to idle, done flag set
  //   edge E+N+1      word pushed into the buffer; a new start may be taken
  //   after E+N+1     head and valid show the word when the buffer was empty
  // A start sampled at edge E+N is still inside the word and is ignored.
  // Back-to-back words cost N+1 cycles each, so 9 cycles for 8-bit words.
  //
  // Buffer behaviour:
  //   pop   when valid and ready are both high at an edge
  //   push  at the edge after the last bit, unless both entries are full
  //         and nothing pops in that same cycle
  //   drop  a word that finds the buffer full is lost; overflow sticks high
  // Overflow is cleared by reset only, so recovery from a lost word is a reset.

  // Per-port views of the pins, index 0 carrier, 1 resampler
  logic [1:0]                 data_in;
  logic [1:0]                 start_in;
  logic [1:0]                 ready_in;
  logic [LEN_SEL_W-1:0]       len_sel   [2];

  // Receiver state per port
  rx_state_t                  state_q   [2];
  rx_state_t                  state_d   [2];
  logic [CNT_W-1:0]           cnt_q     [2];
  logic [CNT_W-1:0]           cnt_d     [2];
  logic [HOLD_W-1:0]          shift_q   [2];
  logic [HOLD_W-1:0]          shift_d   [2];
  // Length latched at start so a select change mid-word cannot corrupt it
  logic [LEN_SEL_W-1:0]       len_q     [2];
  logic [LEN_SEL_W-1:0]       len_d     [2];

  // Completion flag, set at the edge that shifts the last bit
  logic [1:0]                 done_q;
  logic [1:0]                 done_d;
  // Finished word, left-justified, read only while done is high
  logic [HOLD_W-1:0]          word_val  [2];

  // Two-entry buffer per port, entry 0 is the holding register
  logic [HOLD_W-1:0]          buf_q     [2][BUF_DEPTH];
  logic [HOLD_W-1:0]          buf_d     [2][BUF_DEPTH];
  logic [1:0]                 fill_q    [2];
  logic [1:0]                 fill_d    [2];
  logic [1:0]                 push_ok;
  logic [1:0]                 pop;

  // Registered flags behind the valid and overflow outputs
  logic [1:0]                 valid_q;
  logic [1:0]                 valid_d;
  logic [1:0]                 ovf_q;
  logic [1:0]                 ovf_d;

  // Buffer occupancy after one cycle of push and pop
  // A push and a pop in one cycle leave the count as it was
  function automatic logic [1:0] fill_next(input logic [1:0] fill, input logic wr, input logic rd);
    logic [1:0] nxt;
    nxt = fill;
    if (wr && !rd) begin
      nxt = fill + 2'h1;
    end else if (rd && !wr) begin
      nxt = fill - 2'h1;
    end
    return nxt;
  endfunction

  // Port wiring into arrays; both ports are fully independent
  assign data_in    = {resampler_offset_serial_data_i, carrier_offset_serial_data_i};
  assign start_in   = {resampler_word_start_i, carrier_word_start_i};
  assign ready_in   = {resampler_hold_ready_i, carrier_hold_ready_i};
  assign len_sel[0] = carrier_len_sel_i;
  assign len_sel[1] = resampler_len_sel_i;

  // Receiver next state: wait for start, count down, shift one bit a clock
  // Starts seen while shifting fall into the shift branch and are ignored
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      state_d[p] = state_q[p];
      cnt_d[p]   = cnt_q[p];
      shift_d[p] = shift_q[p];
      len_d[p]   = len_q[p];
      case (state_q[p])
        ST_IDLE: begin
          // Clearing the shifter keeps an aborted word from leaking later
          if (start_in[p]) begin
            state_d[p] = ST_SHIFT;
            cnt_d[p]   = word_bits(len_sel[p]);
            len_d[p]   = len_sel[p];
            shift_d[p] = HOLD_RST;
          end
        end
        ST_SHIFT: begin
          // New bit enters at the bottom, so the first bit ends highest
          shift_d[p] = {shift_q[p][HOLD_W-2:0], data_in[p]};
          cnt_d[p]   = cnt_q[p] - 6'h01;
          if (cnt_q[p] == 6'h01) begin
            // Idle again at once, so the next start may follow directly
            state_d[p] = ST_IDLE;
          end
        end
        default: begin
          state_d[p] = ST_IDLE;
        end
      endcase
    end
  end

  // Receiver registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int p = 0; p < 2; p++) begin
        state_q[p] <= ST_IDLE;
        cnt_q[p]   <= CNT_RST;
        shift_q[p] <= HOLD_RST;
        len_q[p]   <= LEN_SEL_8;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        state_q[p] <= state_d[p];
        cnt_q[p]   <= cnt_d[p];
        shift_q[p] <= shift_d[p];
        len_q[p]   <= len_d[p];
      end
    end
  end

  // Completion: the last bit is being shifted in this cycle
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      done_d[p] = (state_q[p] == ST_SHIFT) && (cnt_q[p] == 6'h01);
    end
  end

  // Completion registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      done_q <= 2'h0;
    end else begin
      done_q <= done_d;
    end
  end

  // Two-entry buffer per port; head entry is the holding register
  // Back-to-back words need the buffer: a stalled drain keeps the head
  // The shifter still holds the word while done is high, even when a new
  // start is taken in the same cycle, because that start clears it only
  // at the following edge
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      word_val[p] = left_justify(shift_q[p], len_q[p]);
      pop[p]      = valid_q[p] && ready_in[p];
      push_ok[p]  = done_q[p] && !(fill_q[p] == 2'h2 && !pop[p]);
      buf_d[p][0] = buf_q[p][0];
      buf_d[p][1] = buf_q[p][1];
      ovf_d[p]    = ovf_q[p];
      // Second entry moves forward on a pop
      if (pop[p]) begin
        buf_d[p][0] = buf_q[p][1];
      end
      // New word lands in the first entry that is free after the pop
      if (push_ok[p]) begin
        if (fill_q[p] == 2'h0 || (fill_q[p] == 2'h1 && pop[p])) begin
          buf_d[p][0] = word_val[p];
        end else begin
          buf_d[p][1] = word_val[p];
        end
      end
      // Full and not draining: the word is dropped and flagged
      if (done_q[p] && !push_ok[p]) begin
        ovf_d[p] = 1'b1;
      end
      fill_d[p]  = fill_next(fill_q[p], push_ok[p], pop[p]);
      valid_d[p] = (fill_d[p] != 2'h0);
    end
  end

  // Buffer registers
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int p = 0; p < 2; p++) begin
        buf_q[p][0] <= HOLD_RST;
        buf_q[p][1] <= HOLD_RST;
        fill_q[p]   <= 2'h0;
      end
      valid_q <= 2'h0;
      ovf_q   <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        buf_q[p][0] <= buf_d[p][0];
        buf_q[p][1] <= buf_d[p][1];
        fill_q[p]   <= fill_d[p];
      end
      valid_q <= valid_d;
      ovf_q   <= ovf_d;
    end
  end

  // Outputs straight from flip-flops
  // Valid has its own register so no compare sits after the flops
  assign carrier_offset_hold_o   = buf_q[0][0];
  assign resampler_offset_hold_o = buf_q[1][0];
  assign carrier_hold_valid_o    = valid_q[0];
  assign resampler_hold_valid_o  = valid_q[1];
  assign carrier_overflow_o      = ovf_q[0];
  assign resampler_overflow_o    = ovf_q[1];

  // Limitations:
  //   the length select is read only at the start edge of each word
  //   a sender that keeps start high is seen as one start per word, since
  //   starts are ignored while shifting
  //   data pins are taken as already synchronous to the system clock
  //   entry 1 keeps a stale copy after a pop; only the fill count decides
  //   whether it is live

endmodule // serial_offset_frequency_loader

// ===== test/serial_offset_props.sv
// Purpose: Port checks for the serial offset loader
// Assumes: One clock, async active-low reset
// Notes:   A shadow shifter mirrors the carrier port
`timescale 1ns/1ps
module serial_offset_props (
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        arst_n_i,
  // Carrier port inputs
  input wire logic        carrier_offset_serial_data_i,
  input wire logic        carrier_word_start_i,
  input wire logic [1:0]  carrier_len_sel_i,
  input wire logic        carrier_hold_ready_i,
  // Watched outputs
  input wire logic        carrier_hold_valid_o,
  input wire logic        carrier_overflow_o,
  input wire logic        resampler_hold_valid_o,
  input wire logic        resampler_overflow_o,
  input wire logic [31:0] carrier_offset_hold_o
);
  logic [5:0]  cnt_q, n_q;
  logic [31:0] sh_q, word_q;
  // Shadow ignores mid-word starts; stale high bits fall off the final shift
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q  <= 6'h00;
      n_q    <= 6'h00;
      sh_q   <= 32'h0;
      word_q <= 32'h0;
    end else if (cnt_q == 6'h00) begin
      if (carrier_word_start_i) begin
        cnt_q <= {({1'b0, carrier_len_sel_i} + 3'h1), 3'h0};
        n_q   <= {({1'b0, carrier_len_sel_i} + 3'h1), 3'h0};
      end
    end else begin
      cnt_q <= cnt_q - 6'h01;
      sh_q  <= {sh_q[30:0], carrier_offset_serial_data_i};
      if (cnt_q == 6'h01) word_q <= {sh_q[30:0], carrier_offset_serial_data_i} << (6'h20 - n_q);
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  reset_clear_a: assert property ($rose(arst_n_i) |-> !carrier_hold_valid_o && !resampler_hold_valid_o
    && !carrier_overflow_o && !resampler_overflow_o) else $error("outputs set after reset");
  word_done_a: assert property (cnt_q == 6'h01 && !carrier_hold_valid_o |=>
    !carrier_hold_valid_o ##1 carrier_hold_valid_o) else $error("word latency wrong");
  valid_cause_a: assert property ($rose(carrier_hold_valid_o) |-> $past(cnt_q, 2) == 6'h01)
    else $error("valid without word");
  hold_value_a: assert property ($rose(carrier_hold_valid_o) |-> carrier_offset_hold_o == word_q)
    else $error("held word wrong");
  hold_stand_a: assert property (carrier_hold_valid_o && !carrier_hold_ready_i |=>
    carrier_hold_valid_o && $stable(carrier_offset_hold_o)) else $error("held word lost");
  ovf_cause_a: assert property ($rose(carrier_overflow_o) |-> $past(cnt_q, 2) == 6'h01)
    else $error("overflow without word");
  ovf_stick_a: assert property (carrier_overflow_o |=> carrier_overflow_o)
    else $error("overflow cleared");
  res_stick_a: assert property (resampler_overflow_o |=> resampler_overflow_o)
    else $error("overflow cleared");
endmodule // serial_offset_props

bind serial_offset_frequency_loader serial_offset_props u_props (.clk_sys_i, .arst_n_i,
  .carrier_offset_serial_data_i, .carrier_word_start_i, .carrier_len_sel_i, .carrier_hold_ready_i,
  .carrier_hold_valid_o, .carrier_overflow_o, .resampler_hold_valid_o, .resampler_overflow_o,
  .carrier_offset_hold_o);

// ===== test/offset_word_sender.sv
// Purpose: Tracking loop model sending serial offset words
// Assumes: Drives on the falling edge; go is a level
// Notes:   Idle data toggles so a stale bit never looks valid
`timescale 1ns/1ps
module offset_word_sender (
  // Request
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [1:0]  len_i,
  input  wire logic [31:0] word_i,
  // Serial port
  output logic             start_o = 1'b0,
  output logic             data_o = 1'b0
);
  logic [31:0] sh_q;
  logic [5:0]  cnt_q = 6'h00;
  // One bit a clock, next start right after the last bit
  always @(negedge clk_i) begin
    start_o <= 1'b0;
    data_o  <= ~data_o;
    if (cnt_q != 6'h00) begin
      data_o <= sh_q[31];
      sh_q   <= sh_q << 1;
      cnt_q  <= cnt_q - 6'h01;
    end else if (go_i) begin
      start_o <= 1'b1;
      sh_q    <= word_i;
      cnt_q   <= {({1'b0, len_i} + 3'h1), 3'h0};
    end
  end
endmodule // offset_word_sender

// ===== test/serial_offset_frequency_loader_tb.sv
// Purpose: Self-checking bench for the serial offset loader
// Assumes: Sender models feed both ports
// Notes:   Expected words are masks of the sent words
`timescale 1ns/1ps
module serial_offset_frequency_loader_tb;
  import serial_offset_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        xs = 1'b0;
  logic        go [2] = '{1'b0, 1'b0};
  logic        rdy [2] = '{1'b0, 1'b0};
  logic [1:0]  len [2] = '{2'h0, 2'h0};
  logic [31:0] w [2] = '{32'h0, 32'h0};
  logic [31:0] h [2];
  logic        st [2], sd [2], v [2], of [2];
  int          fail_count = 0;
  int          total_checks = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  // Carrier and resampler far ends
  offset_word_sender snd_c (.clk_i(clk_sys_i), .go_i(go[0]), .len_i(len[0]), .word_i(w[0]), .start_o(st[0]),
    .data_o(sd[0]));
  offset_word_sender snd_r (.clk_i(clk_sys_i), .go_i(go[1]), .len_i(len[1]), .word_i(w[1]), .start_o(st[1]),
    .data_o(sd[1]));
  serial_offset_frequency_loader uut (.clk_sys_i, .arst_n_i, .carrier_len_sel_i(len[0]),
    .resampler_len_sel_i(len[1]), .carrier_offset_serial_data_i(sd[0]), .carrier_word_start_i(st[0] | xs),
    .resampler_offset_serial_data_i(sd[1]), .resampler_word_start_i(st[1]), .carrier_hold_ready_i(rdy[0]),
    .resampler_hold_ready_i(rdy[1]), .carrier_offset_hold_o(h[0]), .carrier_hold_valid_o(v[0]),
    .resampler_offset_hold_o(h[1]), .resampler_hold_valid_o(v[1]), .carrier_overflow_o(of[0]),
    .resampler_overflow_o(of[1]));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // Hold go until the start pulse has been sampled
  task automatic send(input int p, input logic [1:0] l, input logic [31:0] d);
    int i;
    go[p] <= 1'b1;
    len[p] <= l;
    w[p] <= d;
    for (i = 0; i < 40 && st[p] !== 1'b1; i++) @(posedge clk_sys_i);
    if (i >= 40) begin
      check("start_seen", 32'h1, 32'h0);
      stop_test();
    end
    @(negedge clk_sys_i);
    go[p] <= 1'b0;
    // Let one edge pass so the next call never re-raises go in this step
    @(negedge clk_sys_i);
  endtask
  // Wait for a held word, compare it, pop it
  task automatic pop(input int p, input logic [31:0] e);
    int i;
    for (i = 0; i < 60 && v[p] !== 1'b1; i++) @(negedge clk_sys_i);
    if (i >= 60) begin
      check("valid_seen", 32'h1, 32'h0);
      stop_test();
    end
    check("hold", e, h[p]);
    rdy[p] <= 1'b1;
    @(negedge clk_sys_i);
    rdy[p] <= 1'b0;
  endtask
  // Every length on both ports at once
  task automatic t_lengths();
    for (int l = 0; l < 4; l++) begin
      send(0, l[1:0], 32'h9a5c_3e71);
      send(1, 2'h3 - l[1:0], 32'h6c1f_8b25);
      pop(0, 32'h9a5c_3e71 & ~(32'hffff_ffff >> (8 * (l + 1))));
      pop(1, 32'h6c1f_8b25 & ~(32'hffff_ffff >> (8 * (4 - l))));
    end
  endtask
  // Stray starts mid-word and on the last bit
  task automatic t_midstart();
    // Send returns six ns after the start edge: g=2 hits bit 4, g=14 the last bit
    for (int g = 2; g <= 14; g += 12) begin
      send(0, 2'h1, 32'hc3a5_0f96);
      repeat (g) @(negedge clk_sys_i);
      xs <= 1'b1;
      @(negedge clk_sys_i);
      xs <= 1'b0;
      pop(0, 32'hc3a5_0000);
      repeat (40) @(negedge clk_sys_i);
      check("extra", 32'h0, {31'h0, v[0]});
    end
  endtask
  // Three gapless bytes into a stalled buffer
  task automatic t_fill();
    send(0, 2'h0, 32'ha1ff_ffff);
    send(0, 2'h0, 32'hb2ff_ffff);
    send(0, 2'h0, 32'hc3ff_ffff);
    repeat (12) @(negedge clk_sys_i);
    check("ovf", 32'h1, {31'h0, of[0]});
    pop(0, 32'ha100_0000);
    pop(0, 32'hb200_0000);
    check("drop", 32'h0, {30'h0, of[1], v[0]});
  endtask
  initial begin
    repeat (3) @(negedge clk_sys_i);
    arst_n_i <= 1'b1;
    check("idle", 32'h0, {30'h0, v[1], v[0]});
    t_lengths();
    t_midstart();
    t_fill();
    stop_test();
  end
endmodule // serial_offset_frequency_loader_tb
